// ===== slo_map.svh
// constants for the synthetic loss and delay oam endpoint engine
`ifndef SLO_MAP_SVH
`define SLO_MAP_SVH

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SLO_CNT_RST      32'h0000_0000
`define SLO_FLAG_RST     1'b0
`define SLO_PEER_RST     8'h00

// ----------------------------------------------------------------
// pdu field values, counter steps, buffer depth and last domain code
// ----------------------------------------------------------------
`define SLO_CNT_STEP     32'h0000_0001
`define SLO_TLV_OFS_EXT  8'h14
`define SLO_END_TLV      8'h00
`define SLO_BUF_DEPTH    2'h2
`define SLO_BUF_ONE      2'h1
`define SLO_DOM_LAST     2'h2

`endif

// ===== slo_pkg.sv
// types shared by the synthetic loss and delay oam endpoint engine
package slo_pkg;

  // ----------------------------------------------------------------
  // pdu kinds seen by a lookup
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SLO_PDU_OTHER = 3'h0,
    SLO_PDU_SLM   = 3'h1,
    SLO_PDU_SLR   = 3'h2,
    SLO_PDU_SL1   = 3'h3,
    SLO_PDU_DMM   = 3'h4,
    SLO_PDU_DMR   = 3'h5,
    SLO_PDU_DM1   = 3'h6
  } slo_pdu_e;

  typedef logic [31:0] slo_cnt_t;
  typedef logic [63:0] slo_ts_t;
  typedef logic [12:0] slo_mepid_t;
  typedef logic [1:0]  slo_dom_t;

  // lookup request from the switch pipeline
  typedef struct packed {
    slo_pdu_e   kind;     // pdu type
    logic       rx;       // 1: rx lookup, 0: tx lookup
    logic       pdu_ok;   // pdu passed validation
    logic [2:0] peer;     // synthetic_peer_index
    logic       up_ep;    // up-endpoint lookup
    logic [2:0] port;     // front port
  } slo_req_s;

  // lookup answer: counts, field writes and frame actions
  typedef struct packed {
    slo_pdu_e   kind;
    logic       rx;
    logic [2:0] peer;
    logic       count_oam;   // bump oam pdu tx/rx counter
    logic       count_flm;   // include in frame loss counters
    logic       wr_fwd_tx;   // write forward tx count field
    slo_cnt_t   fwd_tx;
    logic       wr_bwd_tx;   // write backward tx count field
    slo_cnt_t   bwd_tx;
    logic       wr_rsp_id;   // overwrite responder endpoint id
    slo_mepid_t rsp_id;
    logic       ins_rx;      // insert rx count after backward tx
    logic       wr_rsvd;     // write rx count into reserved field
    slo_cnt_t   rx_cnt;
    logic [7:0] tlv_ofs;     // new tlv offset when ins_rx
    logic [7:0] end_tlv;     // appended end tlv when ins_rx
    logic       wr_ts;       // write timestamp field
    slo_ts_t    ts;
    slo_dom_t   ts_dom;
    logic       loop;        // inject reply toward the peer
    logic       extract;     // copy to cpu
  } slo_rsp_s;

endpackage : slo_pkg

// ===== slo_engine.sv
// synthetic loss and delay measurement oam endpoint engine
`timescale 1ns/10ps
`include "slo_map.svh"

// Overview of operation
// - hw processing off: loss pdus pass unmodified, still counted
// - oam count: slm by request enable, slr and 1sl by reply
// - valid slm and slr always count in frame loss counters
// - tx slm writes synthetic count to forward field, then bumps it
// - rx slm sets request flag
// - loopback turns each valid rx slm into injected slr
// - request copy extracts every valid rx slm
// - tx slr writes peer tx loss count to backward field
// - tx slr responder id set to local endpoint id
// - rx slr sets reply flag
// - insert enable sets tlv offset 20 and adds 32-bit rx count
// - extended slr gets zero end tlv after inserted count
// - peer rx loss count bumps only after sampling
// - per-peer extraction of rx slr and 1sl, optionally hit-me-once
// - reply copy extracts every valid rx slr or 1sl
// - tx 1sl writes synthetic count to forward field, then bumps it
// - rx 1sl sets flag, writes peer rx count to reserved field, bumps
// - one delay type per endpoint, shared counters; pdus pick it
// - external stamping keeps loop and extract, leaves stamps alone
// - up-endpoint tx stamps at analyzer, rx at rewriter
// - stamp in port's domain, one of three, set per port for analyzer and rewriter
// - dmm and dmr modified only under their own enables
// - slm processing by request hw enable, slr and 1sl by reply
module slo_engine #(
  parameter int NUM_PEERS = 8,   // synthetic peer list length
  parameter int NUM_PORTS = 8    // front ports with a domain setting
) (
  input  wire  logic                         MCLK_I,                     // core clock, 125 MHz
  input  wire  logic                         RST_N_I,                    // synchronous reset, active low
  input  wire  logic                         CE_I,                       // clock enable, freezes all state
  input  wire  logic                         REQ_VALID_I,                // lookup request valid
  output logic                               REQ_READY_O,                // engine can take a request
  input  wire  slo_pkg::slo_req_s            REQ_I,                      // lookup request
  output logic                               RSP_VALID_O,                // answer valid
  input  wire  logic                         RSP_READY_I,                // pipeline takes answer
  output slo_pkg::slo_rsp_s                  RSP_O,                      // lookup answer
  input  wire  logic                         LOSS_REQUEST_HW_EN_I,       // slm hardware processing
  input  wire  logic                         LOSS_REPLY_HW_EN_I,         // slr and 1sl hardware processing
  input  wire  logic                         DELAY_REQUEST_HW_EN_I,      // dmm hardware processing
  input  wire  logic                         DELAY_REPLY_HW_EN_I,        // dmr hardware processing
  input  wire  logic                         DELAY_ONE_WAY_HW_EN_I,      // 1dm hardware processing
  input  wire  logic                         LOSS_REQUEST_OAM_COUNT_EN_I,// slm oam counting
  input  wire  logic                         LOSS_REPLY_OAM_COUNT_EN_I,  // slr and 1sl oam counting
  input  wire  logic                         LOSS_REQUEST_LOOPBACK_EN_I, // loop rx slm as slr
  input  wire  logic                         LOSS_REQUEST_CPU_COPY_EN_I, // copy all rx slm
  input  wire  logic                         LOSS_REPLY_CPU_COPY_EN_I,   // copy all rx slr and 1sl
  input  wire  logic                         RX_COUNT_INSERT_EN_I,       // extend rx slr with rx count
  input  wire  logic [NUM_PEERS-1:0]         PER_PEER_EXTRACT_SEL_I,     // per-peer rx extraction
  input  wire  logic                         EXTRACT_ONCE_EN_I,          // hit-me-once extraction
  input  wire  logic [NUM_PEERS-1:0]         EXTRACT_REARM_I,            // pulse, rearm hit-me-once per peer
  input  wire  logic                         EXTERNAL_TIMESTAMP_SEL_I,   // phy stamps delay pdus
  input  wire  slo_pkg::slo_mepid_t          LOCAL_ENDPOINT_ID_I,        // local endpoint id
  input  wire  slo_pkg::slo_dom_t [NUM_PORTS-1:0] ANA_DOMAIN_SEL_I,      // analyzer modifier domains
  input  wire  slo_pkg::slo_dom_t [NUM_PORTS-1:0] REW_DOMAIN_SEL_I,      // rewriter modifier domains
  input  wire  slo_pkg::slo_ts_t  [2:0]      DOMAIN_TIME_I,              // time of each domain
  input  wire  logic                         FLAG_CLEAR_I,               // pulse, clear receive flags
  output logic                               LOSS_REQUEST_RX_FLAG_O,     // sticky rx slm seen
  output logic                               LOSS_REPLY_RX_FLAG_O,       // sticky rx slr seen
  output logic                               ONE_WAY_LOSS_RX_FLAG_O,     // sticky rx 1sl seen
  output slo_pkg::slo_cnt_t                  SYNTHETIC_TX_FRAME_COUNT_O, // synthetic tx frame count
  output slo_pkg::slo_cnt_t                  DELAY_TX_COUNT_O,           // shared dm tx pdu count
  output slo_pkg::slo_cnt_t                  DELAY_RX_COUNT_O            // shared dm rx pdu count
);
  import slo_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  slo_cnt_t   tx_loss [NUM_PEERS];   // per-peer tx loss counters
  slo_cnt_t   rx_loss [NUM_PEERS];   // per-peer rx loss counters
  slo_rsp_s   buf_q   [2];           // entry 0 is the head
  logic [1:0] fill;
  logic [NUM_PEERS-1:0] once_done;   // hit-me-once already taken

  // ----------------------------------------------------------------
  // decode of the request
  // ----------------------------------------------------------------
  wire       take    = REQ_VALID_I & REQ_READY_O;
  wire       pop     = RSP_VALID_O & RSP_READY_I;
  wire       ok      = REQ_I.pdu_ok;
  wire       is_rx   = REQ_I.rx;
  wire       is_slm  = ok & (REQ_I.kind == SLO_PDU_SLM);
  wire       is_slr  = ok & (REQ_I.kind == SLO_PDU_SLR);
  wire       is_sl1  = ok & (REQ_I.kind == SLO_PDU_SL1);
  wire       is_dmm  = ok & (REQ_I.kind == SLO_PDU_DMM);
  wire       is_dmr  = ok & (REQ_I.kind == SLO_PDU_DMR);
  wire       is_dm1  = ok & (REQ_I.kind == SLO_PDU_DM1);
  wire [2:0] peer    = REQ_I.peer;
  wire       peer_ok = 32'(peer) < NUM_PEERS;

  // hardware enables gate field writes, loop, per-peer extraction and the synthetic count; other counts run regardless
  wire hw_req = LOSS_REQUEST_HW_EN_I;
  wire hw_rep = LOSS_REPLY_HW_EN_I;

  // per-kind lookup events
  wire tx_slm = take & is_slm & ~is_rx;
  wire rx_slm = take & is_slm & is_rx;
  wire tx_slr = take & is_slr & ~is_rx;
  wire rx_slr = take & is_slr & is_rx;
  wire tx_sl1 = take & is_sl1 & ~is_rx;
  wire rx_sl1 = take & is_sl1 & is_rx;

  // ----------------------------------------------------------------
  // counter samples: read before the same-cycle increment lands
  // ----------------------------------------------------------------
  wire slo_cnt_t tx_sample = peer_ok ? tx_loss[peer] : `SLO_CNT_RST;
  wire slo_cnt_t rx_sample = peer_ok ? rx_loss[peer] : `SLO_CNT_RST;

  // ----------------------------------------------------------------
  // timestamp domain selection
  // ----------------------------------------------------------------
  // a domain code past the last domain falls back to domain 0
  function automatic slo_dom_t dom_fix(input slo_dom_t d);
    dom_fix = (d > `SLO_DOM_LAST) ? slo_dom_t'(0) : d;
  endfunction : dom_fix

  // up-endpoints: tx stamps at analyzer modifier, rx at rewriter modifier
  wire      use_ana = REQ_I.up_ep ? ~is_rx : is_rx;
  wire      port_ok = 32'(REQ_I.port) < NUM_PORTS;
  wire slo_dom_t ana_dom = port_ok ? dom_fix(ANA_DOMAIN_SEL_I[REQ_I.port]) : slo_dom_t'(0);
  wire slo_dom_t rew_dom = port_ok ? dom_fix(REW_DOMAIN_SEL_I[REQ_I.port]) : slo_dom_t'(0);
  wire slo_dom_t ts_dom  = use_ana ? ana_dom : rew_dom;
  wire slo_ts_t  ts_now  = DOMAIN_TIME_I[ts_dom];

  // delay stamp needs its enable and internal stamping
  wire dm_hw   = (is_dmm & DELAY_REQUEST_HW_EN_I) | (is_dmr & DELAY_REPLY_HW_EN_I)
               | (is_dm1 & DELAY_ONE_WAY_HW_EN_I);
  wire dm_loop = is_dmm & is_rx & DELAY_REQUEST_HW_EN_I;

  // ----------------------------------------------------------------
  // extraction to cpu
  // ----------------------------------------------------------------
  wire peer_sel  = peer_ok & PER_PEER_EXTRACT_SEL_I[peer];
  wire once_ok   = ~EXTRACT_ONCE_EN_I | ~(peer_ok & once_done[peer]);
  wire peer_ext  = (is_slr | is_sl1) & is_rx & peer_sel & once_ok;
  wire all_ext_q = is_slm & is_rx & LOSS_REQUEST_CPU_COPY_EN_I;
  wire all_ext_p = (is_slr | is_sl1) & is_rx & LOSS_REPLY_CPU_COPY_EN_I;

  // ----------------------------------------------------------------
  // answer build
  // ----------------------------------------------------------------
  slo_rsp_s next_rsp;
  always_comb begin
    next_rsp         = '0;
    next_rsp.kind    = REQ_I.kind;
    next_rsp.rx      = is_rx;
    next_rsp.peer    = peer;
    next_rsp.ts_dom  = ts_dom;
    next_rsp.tlv_ofs = `SLO_TLV_OFS_EXT;
    next_rsp.end_tlv = `SLO_END_TLV;
    // oam counting follows the request or reply count enable
    next_rsp.count_oam = (is_slm & LOSS_REQUEST_OAM_COUNT_EN_I)
                       | ((is_slr | is_sl1) & LOSS_REPLY_OAM_COUNT_EN_I);
    next_rsp.count_flm = is_slm | is_slr;
    // forward tx count for tx slm and tx 1sl
    next_rsp.wr_fwd_tx = ~is_rx & ((is_slm & hw_req) | (is_sl1 & hw_rep));
    next_rsp.fwd_tx    = SYNTHETIC_TX_FRAME_COUNT_O;
    // tx slr: backward count and responder id
    next_rsp.wr_bwd_tx = ~is_rx & is_slr & hw_rep;
    next_rsp.bwd_tx    = tx_sample;
    next_rsp.wr_rsp_id = ~is_rx & is_slr & hw_rep;
    next_rsp.rsp_id    = LOCAL_ENDPOINT_ID_I;
    // rx slr extension carries the count before this pdu
    next_rsp.ins_rx  = is_rx & is_slr & hw_rep & RX_COUNT_INSERT_EN_I;
    next_rsp.wr_rsvd = is_rx & is_sl1 & hw_rep;
    next_rsp.rx_cnt  = rx_sample;
    // timestamp fields left alone under external stamping
    next_rsp.wr_ts = dm_hw & ~EXTERNAL_TIMESTAMP_SEL_I;
    next_rsp.ts    = ts_now;
    // loopback works with internal or external stamping alike
    next_rsp.loop    = (is_slm & is_rx & hw_req & LOSS_REQUEST_LOOPBACK_EN_I) | dm_loop;
    next_rsp.extract = all_ext_q | all_ext_p | (peer_ext & hw_rep);
  end

  // ----------------------------------------------------------------
  // synthetic tx frame count
  // ----------------------------------------------------------------
  // field takes the old value; bump follows
  wire      syn_bump = (tx_slm & hw_req) | (tx_sl1 & hw_rep);
  slo_cnt_t next_syn;
  assign next_syn = syn_bump ? SYNTHETIC_TX_FRAME_COUNT_O + `SLO_CNT_STEP
                             : SYNTHETIC_TX_FRAME_COUNT_O;

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      SYNTHETIC_TX_FRAME_COUNT_O <= `SLO_CNT_RST;
    end else if (CE_I) begin
      SYNTHETIC_TX_FRAME_COUNT_O <= next_syn;
    end
  end

  // ----------------------------------------------------------------
  // per-peer loss counters
  // ----------------------------------------------------------------
  // answer holds the old value; bump lands after sampling
  for (genvar p = 0; p < NUM_PEERS; p++) begin : g_peer
    wire hit     = peer_ok & (32'(peer) == p);
    wire tx_bump = hit & tx_slr;
    wire rx_bump = hit & (rx_slr | rx_sl1);
    wire set_hmo = hit & take & peer_ext & hw_rep & EXTRACT_ONCE_EN_I;

    always_ff @(posedge MCLK_I) begin
      if (!RST_N_I) begin
        tx_loss[p]   <= `SLO_CNT_RST;
        rx_loss[p]   <= `SLO_CNT_RST;
        once_done[p] <= `SLO_FLAG_RST;
      end else if (CE_I) begin
        if (tx_bump) begin
          tx_loss[p] <= tx_loss[p] + `SLO_CNT_STEP;
        end
        if (rx_bump) begin
          rx_loss[p] <= rx_loss[p] + `SLO_CNT_STEP;
        end
        // a new hit beats a rearm in the same cycle
        once_done[p] <= set_hmo | (once_done[p] & ~EXTRACT_REARM_I[p]);
      end
    end
  end

  // ----------------------------------------------------------------
  // shared delay counters
  // ----------------------------------------------------------------
  // both delay types share these counters; the pdus pick one
  wire dm_tx = take & ~is_rx & (is_dmm | is_dm1);
  wire dm_rx = take & is_rx & (is_dmr | is_dm1);

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      DELAY_TX_COUNT_O <= `SLO_CNT_RST;
      DELAY_RX_COUNT_O <= `SLO_CNT_RST;
    end else if (CE_I) begin
      if (dm_tx) begin
        DELAY_TX_COUNT_O <= DELAY_TX_COUNT_O + `SLO_CNT_STEP;
      end
      if (dm_rx) begin
        DELAY_RX_COUNT_O <= DELAY_RX_COUNT_O + `SLO_CNT_STEP;
      end
    end
  end

  // ----------------------------------------------------------------
  // receive flags
  // ----------------------------------------------------------------
  // set beats clear so no pdu is lost
  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      LOSS_REQUEST_RX_FLAG_O <= `SLO_FLAG_RST;
      LOSS_REPLY_RX_FLAG_O   <= `SLO_FLAG_RST;
      ONE_WAY_LOSS_RX_FLAG_O <= `SLO_FLAG_RST;
    end else if (CE_I) begin
      LOSS_REQUEST_RX_FLAG_O <= rx_slm | (LOSS_REQUEST_RX_FLAG_O & ~FLAG_CLEAR_I);
      LOSS_REPLY_RX_FLAG_O   <= rx_slr | (LOSS_REPLY_RX_FLAG_O & ~FLAG_CLEAR_I);
      ONE_WAY_LOSS_RX_FLAG_O <= rx_sl1 | (ONE_WAY_LOSS_RX_FLAG_O & ~FLAG_CLEAR_I);
    end
  end

  // ----------------------------------------------------------------
  // two-entry answer buffer
  // ----------------------------------------------------------------
  // head in entry 0 keeps the answer a plain flop; a stall drops ready, not an answer
  logic [1:0] next_fill;
  wire  [1:0] fill_pop = pop ? fill - `SLO_BUF_ONE : fill;
  assign next_fill = take ? fill_pop + `SLO_BUF_ONE : fill_pop;
  wire        push_hd  = take & (fill_pop == 2'h0);
  wire        push_b1  = take & (fill_pop == `SLO_BUF_ONE);

  always_ff @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      fill        <= 2'h0;
      buf_q[0]    <= '0;
      buf_q[1]    <= '0;
      REQ_READY_O <= 1'b1;
      RSP_VALID_O <= 1'b0;
    end else if (CE_I) begin
      fill        <= next_fill;
      REQ_READY_O <= next_fill < `SLO_BUF_DEPTH;
      RSP_VALID_O <= next_fill != 2'h0;
      if (push_hd) begin
        buf_q[0] <= next_rsp;
      end else if (pop) begin
        buf_q[0] <= buf_q[1];
      end
      if (push_b1) begin
        buf_q[1] <= next_rsp;
      end
    end
  end

  assign RSP_O = buf_q[0];

endmodule : slo_engine

// ===== slo_engine_properties.sv
// assertions on the ports of the synthetic loss and delay oam engine
`timescale 1ns/10ps
module slo_engine_properties (
  input wire logic              MCLK_I,                     // core clock
  input wire logic              RST_N_I,                    // sync reset, active low
  input wire logic              CE_I,                       // clock enable
  input wire logic              REQ_VALID_I,                // request valid
  input wire logic              REQ_READY_O,                // request ready
  input wire slo_pkg::slo_req_s REQ_I,                      // request
  input wire logic              RSP_VALID_O,                // answer valid
  input wire logic              RSP_READY_I,                // answer taken
  input wire slo_pkg::slo_rsp_s RSP_O,                      // answer
  input wire logic              LOSS_REQUEST_HW_EN_I,       // slm processing
  input wire logic              LOSS_REPLY_HW_EN_I,         // slr and 1sl processing
  input wire logic              EXTERNAL_TIMESTAMP_SEL_I,   // external stamping
  input wire slo_pkg::slo_mepid_t LOCAL_ENDPOINT_ID_I,      // local id
  input wire logic              LOSS_REQUEST_RX_FLAG_O,     // slm flag
  input wire logic              LOSS_REPLY_RX_FLAG_O,       // slr flag
  input wire logic              ONE_WAY_LOSS_RX_FLAG_O,     // 1sl flag
  input wire slo_pkg::slo_cnt_t SYNTHETIC_TX_FRAME_COUNT_O  // synthetic count
);
  import slo_pkg::*;
  // ----------------------------------------------------------------
  // helper decode
  // ----------------------------------------------------------------
  wire logic ok   = REQ_VALID_I & REQ_READY_O & CE_I & REQ_I.pdu_ok;
  wire logic bump = ok & ~REQ_I.rx & ((REQ_I.kind == SLO_PDU_SLM & LOSS_REQUEST_HW_EN_I) |
                                      (REQ_I.kind == SLO_PDU_SL1 & LOSS_REPLY_HW_EN_I));
  default clocking dcb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  answer_hold_a: assert property (RSP_VALID_O && !(RSP_READY_I && CE_I) |=> RSP_VALID_O && $stable(RSP_O))
    else $error("answer moved");
  answer_lat_a: assert property (REQ_VALID_I && REQ_READY_O && CE_I && !RSP_VALID_O |=> RSP_VALID_O)
    else $error("answer late");
  count_bump_a: assert property (bump |=> SYNTHETIC_TX_FRAME_COUNT_O == $past(SYNTHETIC_TX_FRAME_COUNT_O) + 32'h1)
    else $error("count no step");
  count_idle_a: assert property (!bump |=> $stable(SYNTHETIC_TX_FRAME_COUNT_O))
    else $error("count moved");
  slm_flag_a: assert property (ok && REQ_I.rx && REQ_I.kind == SLO_PDU_SLM |=> LOSS_REQUEST_RX_FLAG_O)
    else $error("slm flag");
  slr_flag_a: assert property (ok && REQ_I.rx && REQ_I.kind == SLO_PDU_SLR |=> LOSS_REPLY_RX_FLAG_O)
    else $error("slr flag");
  sl1_flag_a: assert property (ok && REQ_I.rx && REQ_I.kind == SLO_PDU_SL1 |=> ONE_WAY_LOSS_RX_FLAG_O)
    else $error("1sl flag");
  tlv_extend_a: assert property (RSP_VALID_O && RSP_O.ins_rx |-> RSP_O.tlv_ofs == 8'h14 && RSP_O.end_tlv == 8'h00)
    else $error("slr extension");
  rsp_id_a: assert property (RSP_VALID_O && RSP_O.wr_rsp_id |-> RSP_O.rsp_id == LOCAL_ENDPOINT_ID_I)
    else $error("responder id");
  ext_stamp_a: assert property (RSP_VALID_O && EXTERNAL_TIMESTAMP_SEL_I |-> !RSP_O.wr_ts)
    else $error("external stamp");
endmodule : slo_engine_properties

bind slo_engine slo_engine_properties i_slo_engine_properties (
  .MCLK_I(MCLK_I), .RST_N_I(RST_N_I), .CE_I(CE_I), .REQ_VALID_I(REQ_VALID_I), .REQ_READY_O(REQ_READY_O),
  .REQ_I(REQ_I), .RSP_VALID_O(RSP_VALID_O), .RSP_READY_I(RSP_READY_I), .RSP_O(RSP_O),
  .LOSS_REQUEST_HW_EN_I(LOSS_REQUEST_HW_EN_I), .LOSS_REPLY_HW_EN_I(LOSS_REPLY_HW_EN_I),
  .EXTERNAL_TIMESTAMP_SEL_I(EXTERNAL_TIMESTAMP_SEL_I), .LOCAL_ENDPOINT_ID_I(LOCAL_ENDPOINT_ID_I),
  .LOSS_REQUEST_RX_FLAG_O(LOSS_REQUEST_RX_FLAG_O), .LOSS_REPLY_RX_FLAG_O(LOSS_REPLY_RX_FLAG_O),
  .ONE_WAY_LOSS_RX_FLAG_O(ONE_WAY_LOSS_RX_FLAG_O), .SYNTHETIC_TX_FRAME_COUNT_O(SYNTHETIC_TX_FRAME_COUNT_O));

// ===== slo_sink_model.sv
// pipeline consumer that takes answers promptly, slowly or not at all
`timescale 1ns/10ps
module slo_sink_model (
  input  wire logic clk_i,    // core clock
  input  wire logic rst_n_i,  // sync reset, active low
  input  wire logic hold_i,   // refuse every answer
  input  wire logic slow_i,   // take one cycle in four
  output logic      ready_o   // answer taken
);
  logic [1:0] phase;
  // free-running phase varies where slow mode stalls
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) phase <= 2'h0;
    else phase <= phase + 2'h1;
  end
  assign ready_o = !hold_i && (!slow_i || phase == 2'h3);
endmodule : slo_sink_model

// ===== tb_top.sv
// self-checking bench for the synthetic loss and delay oam engine
`timescale 1ns/10ps
module tb_top;
  import slo_pkg::*;
  logic clk, rst_n, req_valid, rsp_valid, rsp_ready, req_ready, hold, slow;
  logic [12:0] en;  // 0 req hw,1 rep hw,2 dmm,3 dmr,5 req oam,6 rep oam,7 loop,8/9 copy,10 ins,11 once,12 ext
  logic [7:0] sel;
  logic [2:0] flags;
  slo_req_s req;
  slo_rsp_s rsp_o, rsp;
  slo_dom_t [7:0] ana, rew;
  slo_ts_t [2:0] tm;
  slo_cnt_t syn, dtx, drx;
  int miscompares, num_checks, cycles;
  localparam slo_mepid_t LOC_ID = 13'h0abc;
  // ----------------------------------------------------------------
  // design, consumer and clock
  // ----------------------------------------------------------------
  slo_engine i_slo_engine (.MCLK_I(clk), .RST_N_I(rst_n), .CE_I(1'b1), .REQ_VALID_I(req_valid),
    .REQ_READY_O(req_ready), .REQ_I(req), .RSP_VALID_O(rsp_valid), .RSP_READY_I(rsp_ready), .RSP_O(rsp_o),
    .LOSS_REQUEST_HW_EN_I(en[0]), .LOSS_REPLY_HW_EN_I(en[1]), .DELAY_REQUEST_HW_EN_I(en[2]),
    .DELAY_REPLY_HW_EN_I(en[3]), .DELAY_ONE_WAY_HW_EN_I(en[4]), .LOSS_REQUEST_OAM_COUNT_EN_I(en[5]),
    .LOSS_REPLY_OAM_COUNT_EN_I(en[6]), .LOSS_REQUEST_LOOPBACK_EN_I(en[7]), .LOSS_REQUEST_CPU_COPY_EN_I(en[8]),
    .LOSS_REPLY_CPU_COPY_EN_I(en[9]), .RX_COUNT_INSERT_EN_I(en[10]), .PER_PEER_EXTRACT_SEL_I(sel),
    .EXTRACT_ONCE_EN_I(en[11]), .EXTRACT_REARM_I(8'h00), .EXTERNAL_TIMESTAMP_SEL_I(en[12]),
    .LOCAL_ENDPOINT_ID_I(LOC_ID), .ANA_DOMAIN_SEL_I(ana), .REW_DOMAIN_SEL_I(rew), .DOMAIN_TIME_I(tm),
    .FLAG_CLEAR_I(1'b0), .LOSS_REQUEST_RX_FLAG_O(flags[0]), .LOSS_REPLY_RX_FLAG_O(flags[1]),
    .ONE_WAY_LOSS_RX_FLAG_O(flags[2]), .SYNTHETIC_TX_FRAME_COUNT_O(syn), .DELAY_TX_COUNT_O(dtx),
    .DELAY_RX_COUNT_O(drx));
  slo_sink_model i_slo_sink_model (.clk_i(clk), .rst_n_i(rst_n), .hold_i(hold), .slow_i(slow),
    .ready_o(rsp_ready));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // ceiling far past the ~100 cycles the tests take
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic check(input string n, input logic [63:0] s, input logic [63:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", n, e, s);
    end
  endtask : check
  // hold request until the edge that takes it
  task automatic xfer(input slo_pdu_e k, input logic rx, input logic [2:0] p, input logic up, input logic wait_rsp);
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{kind: k, rx: rx, pdu_ok: 1'b1, peer: p, up_ep: up, port: 3'h2};
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req_valid <= 1'b0;
    if (wait_rsp) get();
  endtask : xfer
  task automatic get();
    @(negedge clk);
    while (!(rsp_valid === 1'b1 && rsp_ready === 1'b1)) @(negedge clk);
    rsp = rsp_o;
    @(posedge clk);
  endtask : get
  task automatic test_done();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, req_valid, hold, slow, en, sel, req} = '0;
    ana = '0;
    rew = '0;
    ana[2] = 2'h1;
    rew[2] = 2'h2;
    tm = {64'h3333, 64'h2222, 64'h1111};
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    check("ready", req_ready, 1'b1);
    check("flags", flags, 3'h0);
    @(posedge clk) en <= 13'h0020;
    xfer(SLO_PDU_SLM, 1'b0, 3'h0, 1'b0, 1'b1);
    check("slm off wr", rsp.wr_fwd_tx, 1'b0);
    check("slm oam", rsp.count_oam, 1'b1);
    check("slm flm", rsp.count_flm, 1'b1);
    check("syn off", syn, 32'h0);
    en <= 13'h0003;
    slow <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      xfer(SLO_PDU_SLM, 1'b0, 3'h0, 1'b0, 1'b1);
      check("slm fwd", rsp.fwd_tx, 64'(i));
      check("slm oam off", rsp.count_oam, 1'b0);
      xfer(SLO_PDU_SLR, 1'b0, 3'h3, 1'b0, 1'b1);
      check("slr bwd", {rsp.wr_bwd_tx, rsp.bwd_tx}, {1'b1, 32'(i)});
      check("slr id", {rsp.wr_rsp_id, rsp.rsp_id}, {1'b1, LOC_ID});
    end
    xfer(SLO_PDU_SL1, 1'b0, 3'h0, 1'b0, 1'b1);
    check("1sl fwd", {rsp.wr_fwd_tx, rsp.fwd_tx}, {1'b1, 32'h2});
    check("syn", syn, 32'h3);
    en <= 13'h0c03;
    sel <= 8'h08;
    for (int i = 0; i < 2; i++) begin
      xfer(SLO_PDU_SLR, 1'b1, 3'h3, 1'b0, 1'b1);
      check("slr ins", {rsp.ins_rx, rsp.tlv_ofs, rsp.end_tlv}, {1'b1, 8'h14, 8'h00});
      check("slr rx", rsp.rx_cnt, 64'(i));
      check("slr once", rsp.extract, 1'(i == 0));
    end
    check("slr flag", flags[1], 1'b1);
    xfer(SLO_PDU_SL1, 1'b1, 3'h3, 1'b0, 1'b1);
    check("1sl rsvd", {rsp.wr_rsvd, rsp.rx_cnt}, {1'b1, 32'h2});
    check("1sl flag", flags[2], 1'b1);
    en <= 13'h0383;
    xfer(SLO_PDU_SLR, 1'b1, 3'h5, 1'b0, 1'b1);
    check("slr copy", rsp.extract, 1'b1);
    xfer(SLO_PDU_SLM, 1'b1, 3'h6, 1'b0, 1'b1);
    check("slm loop copy", {rsp.loop, rsp.extract}, 2'h3);
    check("slm flag", flags[0], 1'b1);
    // only dmm and dmr are sent, one delay type per endpoint
    en <= 13'h0004;
    xfer(SLO_PDU_DMM, 1'b0, 3'h0, 1'b1, 1'b1);
    check("up tx ts", {rsp.wr_ts, rsp.ts}, {1'b1, 64'h2222});
    xfer(SLO_PDU_DMM, 1'b1, 3'h0, 1'b1, 1'b1);
    check("up rx ts", {rsp.wr_ts, rsp.ts, rsp.loop}, {1'b1, 64'h3333, 1'b1});
    en <= 13'h1004;
    xfer(SLO_PDU_DMM, 1'b1, 3'h0, 1'b0, 1'b1);
    check("ext ts", {rsp.wr_ts, rsp.loop}, 2'h1);
    en <= 13'h0000;
    rew[2] <= 2'h1;
    xfer(SLO_PDU_DMR, 1'b0, 3'h0, 1'b0, 1'b1);
    check("dmr off", rsp.wr_ts, 1'b0);
    en <= 13'h0008;
    xfer(SLO_PDU_DMR, 1'b0, 3'h0, 1'b0, 1'b1);
    check("dmr dom", {rsp.wr_ts, rsp.ts}, {1'b1, 64'h2222});
    // consumer stalls: two answers fill the buffer and request ready drops
    hold <= 1'b1;
    xfer(SLO_PDU_OTHER, 1'b0, 3'h0, 1'b0, 1'b0);
    xfer(SLO_PDU_OTHER, 1'b0, 3'h1, 1'b0, 1'b0);
    @(negedge clk);
    check("full", req_ready, 1'b0);
    @(posedge clk) hold <= 1'b0;
    get();
    check("first", rsp.peer, 3'h0);
    get();
    check("second", rsp.peer, 3'h1);
    check("dm cnt", {dtx, drx}, {32'h1, 32'h0});
    test_done();
  end
endmodule : tb_top
